// file: core/ltphc_pkg.sv
package ltphc_pkg;
  typedef enum logic [2:0] {
    LTPHC_PAT_NORMAL = 3'b000,
    LTPHC_PAT_SYNC   = 3'b001,
    LTPHC_PAT_ALT    = 3'b010,
    LTPHC_PAT_CUSTOM = 3'b011,
    LTPHC_PAT_ONES   = 3'b100,
    LTPHC_PAT_TOGGLE = 3'b101,
    LTPHC_PAT_ZEROS  = 3'b110,
    LTPHC_PAT_RAMP   = 3'b111
  } ltphc_pat_t;

  typedef struct packed {
    logic [15:0]       lane12;
    logic [15:0]       lane34;
    logic              ind_sel;
    logic [13:0]       custom;
    logic              ack;
    logic [31:0]       rdata;
    logic [3:0][13:0]  xp;
    logic [3:0][25:0]  yp;
    logic [14:0]       prbs;
    logic [13:0]       ramp;
    logic              toggle;
    logic [15:0]       cnt;
    logic [1:0][55:0]  bufd;
    logic [1:0]        count;
  } ltphc_state_t;
endpackage : ltphc_pkg

// file: core/ltphc_regs.svh
`ifndef LTPHC_REGS_SVH
`define LTPHC_REGS_SVH
// What this block does
// - Lane PRBS enable overrides lane pattern.
// - Lane 1/2 modes at bits 11-9, 8-6.
// - Lane 3/4 modes at bits 7-5, 4-2.
// - Eight pattern codes from normal to ramp.
// - Filter output truncated, or rounded when enabled.
// - Corner field bits 4-1 sets k, 2..10.
// - y = 2^k/(2^k+1)*(x-xprev+yprev).
// - Bit 0 enables filter, reset off.

// ----------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------
`define LTPHC_IDX_LANE12     6'h15
`define LTPHC_IDX_LANE34     6'h17
`define LTPHC_IDX_CFG        6'h20
`define LTPHC_IDX_STATUS     6'h21
`define LTPHC_IDX_CUSTOM     6'h22

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LTPHC_L1_PRBS        15
`define LTPHC_L2_PRBS        14
`define LTPHC_L3_PRBS        13
`define LTPHC_L4_PRBS        12
`define LTPHC_L1_MODE_LSB    9
`define LTPHC_L2_MODE_LSB    6
`define LTPHC_L3_MODE_LSB    5
`define LTPHC_L4_MODE_LSB    2
`define LTPHC_ROUND_BIT      5
`define LTPHC_CORNER_LSB     1
`define LTPHC_HPF_EN_BIT     0
`define LTPHC_IND_SEL_BIT    0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define LTPHC_LANE12_RST     16'h0000
`define LTPHC_LANE34_RST     16'h0000
`define LTPHC_LANE34_MASK    16'h00FC
`define LTPHC_CUSTOM_RST     14'h0000
`define LTPHC_PRBS_SEED      15'h7FFF

// ----------------------------------------
// Filter arithmetic and pattern words
// ----------------------------------------
`define LTPHC_K_MIN          4'h2
`define LTPHC_K_MAX          4'hA
`define LTPHC_FRAC           8
`define LTPHC_HALF_LSB       40'sh0000000080
`define LTPHC_SYNC_WORD      14'h3F80
`define LTPHC_ALT_WORD       14'h2AAA
`define LTPHC_ALT_INV_WORD   14'h1555
`define LTPHC_ONES_WORD      14'h3FFF
`define LTPHC_SMAX           40'sh0000001FFF
`define LTPHC_SMIN           -40'sh0000002000
`endif

// file: core/ltphc_top.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`include "ltphc_regs.svh"

module ltphc_top
  import ltphc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [55:0] in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [55:0] out_data
);

  ltphc_state_t        st_r;
  ltphc_state_t        st_nxt;
  logic                req;
  logic                push;
  logic                pop;
  logic [5:0]          idx;
  logic [31:0]         rd_mux;
  logic                hpf_en;
  logic                round_en;
  logic [3:0]          corner;
  logic [3:0]          k_eff;
  logic signed [39:0]  den;
  logic signed [39:0]  s_v   [4];
  logic signed [39:0]  y_v   [4];
  logic [13:0]         tr_v  [4];
  logic [13:0]         rn_v  [4];
  logic [13:0]         filt_v[4];
  logic [13:0]         lane_v[4];
  logic [2:0]          mode_v[4];
  logic [3:0]          prbs_en;
  logic [55:0]         word;
  logic signed [39:0]  rem0;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [13:0] sat14(input logic signed [39:0] v);
    if (v > `LTPHC_SMAX) begin
      return 14'h1FFF;
    end else if (v < `LTPHC_SMIN) begin
      return 14'h2000;
    end
    return v[13:0];
  endfunction : sat14

  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : be_merge

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~st_r.ack;
  assign avs_readdata    = st_r.rdata;
  assign idx             = avs_address[7:2];
  assign in_ready        = (st_r.count != 2'h2);
  assign out_valid       = (st_r.count != 2'h0);
  assign out_data        = st_r.bufd[0];
  assign push            = in_valid & in_ready;
  assign pop             = out_valid & out_ready;

  // ----------------------------------------
  // Control field decode
  // ----------------------------------------
  assign hpf_en   = st_r.lane12[`LTPHC_HPF_EN_BIT];
  assign round_en = st_r.lane12[`LTPHC_ROUND_BIT];
  assign corner   = st_r.lane12[`LTPHC_CORNER_LSB +: 4];
  // corner sets k
  // Illegal corners are clamped so the divider never sees an untested k
  assign k_eff    = (corner < `LTPHC_K_MIN) ? `LTPHC_K_MIN :
                    (corner > `LTPHC_K_MAX) ? `LTPHC_K_MAX : corner;
  assign den      = (40'sh0000000001 <<< k_eff) + 40'sh0000000001;
  assign prbs_en  = {st_r.lane12[`LTPHC_L4_PRBS], st_r.lane12[`LTPHC_L3_PRBS],
                     st_r.lane12[`LTPHC_L2_PRBS], st_r.lane12[`LTPHC_L1_PRBS]};
  // lane 1 and 2 mode fields
  assign mode_v[0] = st_r.lane12[`LTPHC_L1_MODE_LSB +: 3];
  assign mode_v[1] = st_r.lane12[`LTPHC_L2_MODE_LSB +: 3];
  // lane 3 and 4 mode fields
  assign mode_v[2] = st_r.lane34[`LTPHC_L3_MODE_LSB +: 3];
  assign mode_v[3] = st_r.lane34[`LTPHC_L4_MODE_LSB +: 3];

  always_comb begin
    rd_mux = 32'h00000000;
    case (idx)
      `LTPHC_IDX_LANE12: rd_mux = {16'h0000, st_r.lane12};
      `LTPHC_IDX_LANE34: rd_mux = {16'h0000, st_r.lane34};
      `LTPHC_IDX_CFG:    rd_mux = {31'h00000000, st_r.ind_sel};
      `LTPHC_IDX_STATUS: rd_mux = {st_r.cnt, 14'h0000, st_r.count};
      `LTPHC_IDX_CUSTOM: rd_mux = {18'h00000, st_r.custom};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Filter and pattern datapath
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // first-order high-pass recursion
      // Extra fraction bits in the state keep small k from drifting
      s_v[i] = ((40'(signed'(in_data[i*14 +: 14])) - 40'(signed'(st_r.xp[i])))
                <<< `LTPHC_FRAC) + 40'(signed'(st_r.yp[i]));
      y_v[i] = (s_v[i] <<< k_eff) / den;
      // truncate or round to 14 bits
      tr_v[i] = sat14(y_v[i] >>> `LTPHC_FRAC);
      rn_v[i] = sat14((y_v[i] + `LTPHC_HALF_LSB) >>> `LTPHC_FRAC);
      filt_v[i] = !hpf_en ? in_data[i*14 +: 14] : (round_en ? rn_v[i] : tr_v[i]);
      lane_v[i] = filt_v[i];
      if (st_r.ind_sel) begin
        if (prbs_en[i]) begin
          lane_v[i] = st_r.prbs[13:0];
        end else begin
          case (ltphc_pat_t'(mode_v[i]))
            LTPHC_PAT_NORMAL: lane_v[i] = filt_v[i];
            LTPHC_PAT_SYNC:   lane_v[i] = `LTPHC_SYNC_WORD;
            LTPHC_PAT_ALT:    lane_v[i] = `LTPHC_ALT_WORD;
            LTPHC_PAT_CUSTOM: lane_v[i] = st_r.custom;
            LTPHC_PAT_ONES:   lane_v[i] = `LTPHC_ONES_WORD;
            LTPHC_PAT_TOGGLE: lane_v[i] = st_r.toggle ? `LTPHC_ALT_INV_WORD : `LTPHC_ALT_WORD;
            LTPHC_PAT_ZEROS:  lane_v[i] = 14'h0000;
            LTPHC_PAT_RAMP:   lane_v[i] = st_r.ramp;
            default:          lane_v[i] = filt_v[i];
          endcase
        end
      end
    end
  end

  assign word = {lane_v[3], lane_v[2], lane_v[1], lane_v[0]};
  assign rem0 = 40'((s_v[0] <<< k_eff) - (y_v[0] * den));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    if (req && !st_r.ack) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = rd_mux;
    end
    if (avs_write && st_r.ack) begin
      case (idx)
        `LTPHC_IDX_LANE12: st_nxt.lane12 = be_merge(st_r.lane12, avs_writedata, avs_byteenable);
        `LTPHC_IDX_LANE34: st_nxt.lane34 = be_merge(st_r.lane34, avs_writedata, avs_byteenable)
                                           & `LTPHC_LANE34_MASK;
        `LTPHC_IDX_CFG: begin
          if (avs_byteenable[0]) begin
            st_nxt.ind_sel = avs_writedata[`LTPHC_IND_SEL_BIT];
          end
        end
        `LTPHC_IDX_CUSTOM: begin
          if (avs_byteenable[0]) begin
            st_nxt.custom[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            st_nxt.custom[13:8] = avs_writedata[13:8];
          end
        end
        default: st_nxt.ind_sel = st_r.ind_sel;
      endcase
    end
    if (push) begin
      for (int i = 0; i < 4; i++) begin
        st_nxt.xp[i] = in_data[i*14 +: 14];
        st_nxt.yp[i] = hpf_en ? y_v[i][25:0] : 26'h0000000;
      end
      // Patterns advance per accepted word, not per clock
      st_nxt.prbs   = {st_r.prbs[13:0], st_r.prbs[14] ^ st_r.prbs[13]};
      st_nxt.ramp   = st_r.ramp + 14'h0001;
      st_nxt.toggle = ~st_r.toggle;
      st_nxt.cnt    = st_r.cnt + 16'h0001;
    end
    case ({push, pop})
      2'b10: begin
        if (st_r.count == 2'h0) begin
          st_nxt.bufd[0] = word;
        end else begin
          st_nxt.bufd[1] = word;
        end
        st_nxt.count = st_r.count + 2'h1;
      end
      2'b01: begin
        st_nxt.bufd[0] = st_r.bufd[1];
        st_nxt.count   = st_r.count - 2'h1;
      end
      2'b11: begin
        if (st_r.count == 2'h1) begin
          st_nxt.bufd[0] = word;
        end else begin
          st_nxt.bufd[0] = st_r.bufd[1];
          st_nxt.bufd[1] = word;
        end
      end
      default: st_nxt.count = st_r.count;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r        <= '0;
      st_r.lane12 <= `LTPHC_LANE12_RST;
      st_r.lane34 <= `LTPHC_LANE34_RST;
      st_r.custom <= `LTPHC_CUSTOM_RST;
      st_r.prbs   <= `LTPHC_PRBS_SEED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_bus_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");

  a_buf_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("buffered word lost under stall");

  a_prbs_lane: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.ind_sel && prbs_en[1]) |-> (lane_v[1] == st_r.prbs[13:0]))
    else $error("lane 2 not carrying prbs");

  a_lane1_ones: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.ind_sel && !prbs_en[0] && st_r.lane12[11:9] == 3'b100) |-> lane_v[0] == 14'h3FFF)
    else $error("lane 1 all-ones pattern wrong");

  a_lane3_ramp: assert property (@(posedge mclk) disable iff (!reset_n)
    (push && st_r.ind_sel && !prbs_en[2] && st_r.lane34[7:5] == 3'b111)
    |=> lane_v[2] == $past(lane_v[2]) + 14'h0001 || prbs_en[2] || !st_r.ind_sel
    || st_r.lane34[7:5] != 3'b111)
    else $error("lane 3 ramp not incrementing");

  a_normal_pass: assert property (@(posedge mclk) disable iff (!reset_n)
    (!st_r.ind_sel || (!prbs_en[3] && st_r.lane34[4:2] == 3'b000)) |-> lane_v[3] == filt_v[3])
    else $error("normal mode does not carry data");

  a_round_sel: assert property (@(posedge mclk) disable iff (!reset_n)
    hpf_en |-> (filt_v[0] == (round_en ? rn_v[0] : tr_v[0]))
    && (14'(rn_v[0] - tr_v[0]) <= 14'h0001))
    else $error("rounding option not honoured");

  a_corner_k: assert property (@(posedge mclk) disable iff (!reset_n)
    (k_eff >= 4'h2 && k_eff <= 4'hA && (corner < 4'h2 || corner > 4'hA || k_eff == corner)))
    else $error("filter exponent out of range");

  a_hpf_math: assert property (@(posedge mclk) disable iff (!reset_n)
    (push && hpf_en) |-> (rem0 < den && rem0 > -den
    && (rem0 == 40'sh0000000000 || rem0[39] == s_v[0][39])))
    else $error("filter quotient wrong");

  a_hpf_off: assert property (@(posedge mclk) disable iff (!reset_n)
    (push && !hpf_en) |=> st_r.yp[0] == 26'h0000000 && st_r.xp[0] == $past(in_data[13:0]))
    else $error("filter state not cleared while bypassed");

  a_bypass_data: assert property (@(posedge mclk) disable iff (!reset_n)
    !hpf_en |-> filt_v[0] == in_data[13:0])
    else $error("bypassed filter alters data");

  a_lane34_rsvd: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.lane34 & 16'hFF03) == 16'h0000)
    else $error("reserved lane 3/4 bits stored");

  a_write_lane12: assert property (@(posedge mclk) disable iff (!reset_n)
    (avs_write && !avs_waitrequest && idx == 6'h15 && avs_byteenable[1:0] == 2'h3)
    |=> st_r.lane12 == $past(avs_writedata[15:0]))
    else $error("lane 1/2 control write lost");

  a_read_lane12: assert property (@(posedge mclk) disable iff (!reset_n)
    (avs_read && !avs_waitrequest && idx == 6'h15)
    |-> avs_readdata == {16'h0000, st_r.lane12})
    else $error("lane 1/2 control readback wrong");

  a_prbs_live: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r.prbs != 15'h0000)
    else $error("prbs generator locked at zero");

  a_prbs_all: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.ind_sel && prbs_en == 4'hF) |-> word == {4{st_r.prbs[13:0]}})
    else $error("prbs lanes disagree");

  a_ind_off: assert property (@(posedge mclk) disable iff (!reset_n)
    !st_r.ind_sel |-> word == {filt_v[3], filt_v[2], filt_v[1], filt_v[0]})
    else $error("pattern shown without independent select");

  a_lane1_sync: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.ind_sel && !prbs_en[0] && mode_v[0] == 3'b001) |-> lane_v[0] == 14'h3F80)
    else $error("lane 1 sync pattern wrong");

  a_lane2_zeros: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.ind_sel && !prbs_en[1] && mode_v[1] == 3'b110) |-> lane_v[1] == 14'h0000)
    else $error("lane 2 all-zeros pattern wrong");

  a_lane2_toggle: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.ind_sel && !prbs_en[1] && mode_v[1] == 3'b101)
    |-> (lane_v[1] == 14'h2AAA || lane_v[1] == 14'h1555))
    else $error("lane 2 toggle pattern wrong");

  a_toggle_flip: assert property (@(posedge mclk) disable iff (!reset_n)
    push |=> st_r.toggle != $past(st_r.toggle))
    else $error("toggle phase not advancing per word");

  a_lane3_custom: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.ind_sel && !prbs_en[2] && mode_v[2] == 3'b011) |-> lane_v[2] == st_r.custom)
    else $error("lane 3 custom pattern wrong");

  a_lane4_alt: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r.ind_sel && !prbs_en[3] && mode_v[3] == 3'b010) |-> lane_v[3] == 14'h2AAA)
    else $error("lane 4 alternating pattern wrong");

  a_count_bound: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r.count != 2'h3)
    else $error("buffer fill beyond two words");

  a_push_empty: assert property (@(posedge mclk) disable iff (!reset_n)
    (push && st_r.count == 2'h0) |=> (out_valid && out_data == $past(word)))
    else $error("word into empty buffer not shown");

  a_pass_through: assert property (@(posedge mclk) disable iff (!reset_n)
    (push && pop && st_r.count == 2'h1) |=> out_data == $past(word))
    else $error("word not passed while draining");

  a_word_order: assert property (@(posedge mclk) disable iff (!reset_n)
    (pop && st_r.count == 2'h2) |=> out_data == $past(st_r.bufd[1]))
    else $error("buffered words out of order");

endmodule : ltphc_top

// file: verification/ltphc_bench.sv
`include "ltphc_regs.svh"

module ltphc_bench
  import ltphc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        in_valid = 1'b0;
  logic        in_ready;
  logic        out_valid;
  logic        out_ready;
  logic [55:0] in_data = 56'h0;
  logic [55:0] out_data;
  logic [1:0]  stall_mode = 2'h0;
  logic [15:0] lane12_s = 16'h0;
  logic [15:0] lane34_s = 16'h0;
  logic [13:0] custom_s = 14'h0;
  logic        ind_s = 1'b0;
  int          seed = 32'hF5D0;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n_words = 0;
  longint      xp_s [4] = '{0, 0, 0, 0};
  longint      yp_s [4] = '{0, 0, 0, 0};
  logic [55:0] exp_q [$];
  logic [14:0] prbs_s = `LTPHC_PRBS_SEED;
  logic [15:0] cfgs [4] = '{16'h0005, 16'h0035, 16'h002B, 16'h0025};

  ltphc_top i_ltphc_top (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  ltphc_rx_model i_ltphc_rx_model (.mclk(mclk), .reset_n(reset_n), .stall_mode(stall_mode),
    .out_ready(out_ready));

  initial begin
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Bus and stream drivers
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd);
    logic w;
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= {idx, 2'h0};
    avs_writedata <= {16'h0, wd};
    // Inputs only move at rising edges, so the falling-edge value is what the edge sees
    do begin
      @(negedge mclk);
      w = avs_waitrequest;
      rd = avs_readdata;
      @(posedge mclk);
    end while (w);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic wreg(input logic [5:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, wd, rd);
    case (idx)
      `LTPHC_IDX_LANE12: lane12_s = wd;
      `LTPHC_IDX_LANE34: lane34_s = wd & 16'h00FC;
      `LTPHC_IDX_CFG:    ind_s = wd[0];
      `LTPHC_IDX_CUSTOM: custom_s = wd[13:0];
      default: ;
    endcase
  endtask : wreg

  task automatic rchk(input logic [5:0] idx, input logic [15:0] e);
    logic [31:0] rd;
    bus(1'b0, idx, 16'h0, rd);
    check({24'h0, rd}, {40'h0, e});
  endtask : rchk

  task automatic send(input int n);
    logic a;
    repeat (n) begin
      if ($random(seed) % 4 == 0) begin
        in_valid <= 1'b0;
        @(posedge mclk);
      end
      in_valid <= 1'b1;
      in_data <= 56'({$random(seed), $random(seed)});
      do begin
        @(negedge mclk);
        a = in_ready;
        @(posedge mclk);
      end while (!a);
    end
    in_valid <= 1'b0;
    @(posedge mclk);
  endtask : send

  // ----------------------------------------
  // Expected lane value; advances the filter state
  // ----------------------------------------
  function automatic logic [13:0] lane_val(input int l, input logic [13:0] x);
    longint s;
    longint k;
    logic [2:0] m;
    logic [13:0] f;
    k = lane12_s[4:1] < 2 ? 2 : (lane12_s[4:1] > 10 ? 10 : lane12_s[4:1]);
    if (lane12_s[0]) begin
      s = ((longint'($signed(x)) - xp_s[l]) <<< 8) + yp_s[l];
      yp_s[l] = (s <<< k) / ((longint'(1) <<< k) + 1);
      s = (yp_s[l] + (lane12_s[5] ? 128 : 0)) >>> 8;
      f = s > 8191 ? 14'h1FFF : (s < -8192 ? 14'h2000 : s[13:0]);
    end else begin
      yp_s[l] = 0;
      f = x;
    end
    xp_s[l] = $signed(x);
    m = l == 0 ? lane12_s[11:9] : l == 1 ? lane12_s[8:6] : l == 2 ? lane34_s[7:5] : lane34_s[4:2];
    if (!ind_s) return f;
    case (ltphc_pat_t'(m))
      LTPHC_PAT_NORMAL: return f;
      LTPHC_PAT_SYNC:   return 14'h3F80;
      LTPHC_PAT_ALT:    return 14'h2AAA;
      LTPHC_PAT_CUSTOM: return custom_s;
      LTPHC_PAT_ONES:   return 14'h3FFF;
      LTPHC_PAT_TOGGLE: return n_words[0] ? 14'h1555 : 14'h2AAA;
      LTPHC_PAT_ZEROS:  return 14'h0000;
      default:          return n_words[13:0];
    endcase
  endfunction : lane_val

  // Sampled at the falling edge: these are the values the next rising edge takes
  always @(negedge mclk) begin
    logic [55:0] e;
    logic [3:0] p;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
    if (reset_n && in_valid && in_ready) begin
      p = ind_s ? {lane12_s[12], lane12_s[13], lane12_s[14], lane12_s[15]} : 4'h0;
      for (int l = 0; l < 4; l++) begin
        e[14*l +: 14] = lane_val(l, in_data[14*l +: 14]);
        // Enabled lanes carry the generator word of this sample
        if (p[l]) begin
          e[14*l +: 14] = prbs_s[13:0];
        end
      end
      prbs_s = {prbs_s[13:0], prbs_s[14] ^ prbs_s[13]};
      exp_q.push_back(e);
      n_words++;
    end
    if (reset_n && out_valid && out_ready) begin
      e = exp_q.pop_front();
      check(out_data, e);
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rchk(`LTPHC_IDX_LANE12, 16'h0000);
    rchk(`LTPHC_IDX_LANE34, 16'h0000);
    rchk(6'h3F, 16'h0000);
    wreg(`LTPHC_IDX_LANE34, 16'h00FC);
    rchk(`LTPHC_IDX_LANE34, 16'h00FC);
    stall_mode <= 2'h1;
    send(20);
    foreach (cfgs[i]) begin
      wreg(`LTPHC_IDX_LANE12, cfgs[i]);
      rchk(`LTPHC_IDX_LANE12, cfgs[i]);
      send(30);
    end
    wreg(`LTPHC_IDX_CFG, 16'h0001);
    for (int m = 0; m < 8; m++) begin
      wreg(`LTPHC_IDX_CUSTOM, 16'($random(seed)) & 16'h3FFF);
      wreg(`LTPHC_IDX_LANE12, 16'((m << 9) | (((m + 1) % 8) << 6) | 9));
      wreg(`LTPHC_IDX_LANE34, 16'((((m + 2) % 8) << 5) | (((m + 3) % 8) << 2)));
      send(12);
    end
    wreg(`LTPHC_IDX_LANE12, 16'hF209);
    send(10);
    stall_mode <= 2'h2;
    in_valid <= 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    check({54'h0, in_ready, out_valid}, 56'h1);
    @(posedge mclk);
    in_valid <= 1'b0;
    stall_mode <= 2'h1;
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge mclk);
    check(56'(exp_q.size()), 56'h0);
    report_and_stop();
  end
endmodule : ltphc_bench

// file: verification/ltphc_rx_model.sv
// ----------------------------------------
// Receiver standing at the output stream
// ----------------------------------------
module ltphc_rx_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [1:0] stall_mode,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h1A2B;
  // Mode 0 always takes, 1 stalls at random, 2 holds off to fill the buffer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= (stall_mode == 2'h0) || (stall_mode == 2'h1 && $random(seed) % 2 == 0);
    end
  end
endmodule : ltphc_rx_model
